/* logic/ncd_bus_writer.sv */
// one asynchronous write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "ncd_cfg.svh"
module ncd_bus_writer (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // cycle request
  input  wire logic                   start,
  input  wire ncd_pkg::ncd_cycle_type cyc,
  output logic                        done,
  // flash pins
  output logic                        we_n,
  output logic [23:0]                 addr,
  output logic [15:0]                 dq_o,
  output logic                        dq_oe
);
  logic [1:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d, done_d, we_n_d, oe_d;
  logic [23:0] addr_d;
  logic [15:0] dq_d;
  // address and data held for the whole low phase of we_n plus one cycle
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    we_n_d = we_n;
    oe_d   = dq_oe;
    addr_d = addr;
    dq_d   = dq_o;
    // no new cycle while done shows, or a start left over from the finishing state repeats that cycle
    if (!busy_q && !done && start) begin
      busy_d = 1'b1;
      cnt_d  = 2'(`NCD_WE_CYCLES);
      addr_d = cyc.addr;
      dq_d   = cyc.data;
      oe_d   = 1'b1;
      we_n_d = 1'b0;
    end else if (busy_q) begin
      if (cnt_q != 2'h0) begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) we_n_d = 1'b1;
      end else begin
        busy_d = 1'b0;
        done_d = 1'b1;
        oe_d   = 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      addr <= 24'h000000;
      dq_o <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done <= done_d;
      we_n <= we_n_d;
      dq_oe <= oe_d;
      addr <= addr_d;
      dq_o <= dq_d;
    end
  end
endmodule
`default_nettype wire

/* logic/ncd_cfg.svh */
// constants for the flash command sequencer: unlock addresses, command codes, lock layout
`ifndef NCD_CFG_SVH
`define NCD_CFG_SVH
`define NCD_UNLOCK1_X8    12'hAAA
`define NCD_UNLOCK2_X8    12'h555
`define NCD_UNLOCK1_X16   12'h555
`define NCD_UNLOCK2_X16   12'h2AA
`define NCD_CFI_ADDR_X8   12'h0AA
`define NCD_CFI_ADDR_X16  12'h055
`define NCD_KEY1          8'hAA
`define NCD_KEY2          8'h55
`define NCD_CMD_RESET     8'hF0
`define NCD_CMD_CFI       8'h98
`define NCD_CMD_AUTOSEL   8'h90
`define NCD_CMD_BYPASS    8'h20
`define NCD_CMD_BYP_EXIT2 8'h00
`define NCD_CMD_PROGRAM   8'hA0
`define NCD_CMD_DOUBLE    8'h50
`define NCD_CMD_QUAD      8'h56
`define NCD_CMD_OCTUPLE   8'h8B
`define NCD_CMD_BUFFER    8'h25
`define NCD_CMD_ENH_BUF   8'h33
`define NCD_CMD_CONFIRM   8'h29
`define NCD_LOCK_RSVD     16'hFFF8
`define NCD_LOCK_PWD_BIT  2
`define NCD_LOCK_NVM_BIT  1
`define NCD_LOCK_EXT_BIT  0
`define NCD_LOCK_DEFAULT  16'hFFFF
`define NCD_MAX_LOC_X8    9'h100
`define NCD_MAX_LOC_X16   9'h100
`define NCD_WE_CYCLES     2
`endif

/* logic/ncd_host.sv */
// host-side command sequencer that drives flash write cycles
`timescale 1ns/1ps
`default_nettype none
`include "ncd_cfg.svh"
// Behaviour
// - reset is a single F0 write, never after unlocks
// - unlock pair addresses depend on bus width
// - CFI entry is single 98 write
// - identifier mode: unlocks then 90
// - program: unlocks, A0, then data
// - buffer: unlocks, 25, count, data writes
// - enhanced buffer word-only, no count cycle
// - buffer committed by 29 at block address
// - bypass accepts commands without unlocks
module ncd_host (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // user order port
  input  wire logic                 req_valid,
  input  wire ncd_pkg::ncd_req_type req,
  input  wire logic                 word_mode,
  output logic                      req_ready,
  output logic                      req_error,
  // data stream for multi-location programs
  input  wire logic                 wdata_valid,
  input  wire ncd_pkg::ncd_cycle_type wdata,
  output logic                      wdata_ready,
  // lock register shadow, as last known by the host
  output logic [15:0]               lock_shadow,
  // flash pins
  output logic                      flash_we_n,
  output logic [23:0]               flash_addr,
  output logic [15:0]               flash_dq_o,
  output logic                      flash_dq_oe
);
  typedef enum logic [2:0] {
    NCD_S_IDLE   = 3'b000,
    NCD_S_UNLK1  = 3'b001,
    NCD_S_UNLK2  = 3'b011,
    NCD_S_CMD    = 3'b010,
    NCD_S_COUNT  = 3'b110,
    NCD_S_DATA   = 3'b111,
    NCD_S_TAIL   = 3'b101
  } ncd_state_type;

  ncd_state_type         st_q, st_d;
  ncd_pkg::ncd_req_type  r_q, r_d;
  logic [8:0]            left_q, left_d;
  logic                  rdy_q, rdy_d, err_q, err_d, wrdy_q, wrdy_d;
  logic                  fly_q, fly_d;
  logic [15:0]           lock_q, lock_d;
  logic                  start;
  ncd_pkg::ncd_cycle_type cyc;
  logic                  done;
  logic [11:0]           u1, u2;
  logic                  need_unlock;
  logic [7:0]            cmd;
  logic [8:0]            max_loc;

  // unlock addresses follow the bus width
  assign u1 = r_q.op == ncd_pkg::NCD_CFI ? (word_mode ? `NCD_CFI_ADDR_X16 : `NCD_CFI_ADDR_X8) :
              (word_mode ? `NCD_UNLOCK1_X16 : `NCD_UNLOCK1_X8);
  assign u2 = word_mode ? `NCD_UNLOCK2_X16 : `NCD_UNLOCK2_X8;
  assign max_loc = word_mode ? `NCD_MAX_LOC_X16 : `NCD_MAX_LOC_X8;
  // cfi, multi, exit and plain reset go straight to the command cycle
  assign need_unlock = !r_q.bypass && (r_q.op != ncd_pkg::NCD_CFI) && (r_q.op != ncd_pkg::NCD_MULTI) &&
                       (r_q.op != ncd_pkg::NCD_BYP_EXIT) && (r_q.op != ncd_pkg::NCD_RESET);

  // command code per order
  always_comb begin
    unique case (r_q.op)
      ncd_pkg::NCD_RESET:      cmd = `NCD_CMD_RESET;
      ncd_pkg::NCD_CFI:        cmd = `NCD_CMD_CFI;
      ncd_pkg::NCD_AUTOSEL:    cmd = `NCD_CMD_AUTOSEL;
      ncd_pkg::NCD_BYP_ENTER:  cmd = `NCD_CMD_BYPASS;
      ncd_pkg::NCD_BYP_EXIT:   cmd = `NCD_CMD_AUTOSEL;
      ncd_pkg::NCD_PROGRAM:    cmd = `NCD_CMD_PROGRAM;
      ncd_pkg::NCD_MULTI:      cmd = r_q.multi_code;
      ncd_pkg::NCD_BUFFER:     cmd = `NCD_CMD_BUFFER;
      ncd_pkg::NCD_ENH_BUFFER: cmd = `NCD_CMD_ENH_BUF;
      default:                 cmd = `NCD_CMD_PROGRAM;   // lock write uses the program cycle
    endcase
  end

  // sequencer next state
  always_comb begin
    st_d   = st_q;
    r_d    = r_q;
    left_d = left_q;
    rdy_d  = rdy_q;
    err_d  = 1'b0;
    wrdy_d = 1'b0;
    fly_d  = fly_q;
    lock_d = lock_q;
    start  = 1'b0;
    cyc    = '0;
    unique case (st_q)
      NCD_S_IDLE: begin
        if (req_valid && rdy_q) begin
          r_d   = req;
          rdy_d = 1'b0;
          st_d  = NCD_S_UNLK1;
          // enhanced buffer is word-only; plain buffer count bounded by buffer size; lock rules
          if ((req.op == ncd_pkg::NCD_ENH_BUFFER && !word_mode) ||
              (req.op == ncd_pkg::NCD_BUFFER && req.count >= max_loc) ||
              (req.op == ncd_pkg::NCD_LOCK_WRITE &&
               !(req.data[`NCD_LOCK_PWD_BIT] && lock_q[`NCD_LOCK_PWD_BIT]) &&
               !(req.data[`NCD_LOCK_NVM_BIT] && lock_q[`NCD_LOCK_NVM_BIT]))) begin
            err_d = 1'b1;
            rdy_d = 1'b1;
            st_d  = NCD_S_IDLE;
          end
        end
      end
      NCD_S_UNLK1: begin
        if (!need_unlock) st_d = NCD_S_CMD;
        else begin
          start = 1'b1;
          cyc   = '{addr: {12'h000, u1}, data: {8'h00, `NCD_KEY1}};
          if (done) st_d = NCD_S_UNLK2;
        end
      end
      NCD_S_UNLK2: begin
        start = 1'b1;
        cyc   = '{addr: {12'h000, u2}, data: {8'h00, `NCD_KEY2}};
        if (done) st_d = NCD_S_CMD;
      end
      NCD_S_CMD: begin
        start = 1'b1;
        // buffer codes go to the block address, cfi to the CFI address, the rest to the first unlock address
        if (r_q.op == ncd_pkg::NCD_BUFFER || r_q.op == ncd_pkg::NCD_ENH_BUFFER)
          cyc = '{addr: r_q.addr, data: {8'h00, cmd}};
        else
          cyc = '{addr: {12'h000, u1}, data: {8'h00, cmd}};
        if (done) begin
          left_d = r_q.count;
          unique case (r_q.op)
            ncd_pkg::NCD_BUFFER:     st_d = NCD_S_COUNT;
            ncd_pkg::NCD_ENH_BUFFER: st_d = NCD_S_DATA;
            ncd_pkg::NCD_PROGRAM, ncd_pkg::NCD_LOCK_WRITE: begin
              left_d = 9'h000;
              st_d   = NCD_S_DATA;
            end
            ncd_pkg::NCD_MULTI:      st_d = NCD_S_DATA;
            ncd_pkg::NCD_BYP_EXIT:   st_d = NCD_S_TAIL;
            default: begin
              rdy_d = 1'b1;
              st_d  = NCD_S_IDLE;
            end
          endcase
        end
      end
      NCD_S_COUNT: begin
        start = 1'b1;
        cyc   = '{addr: r_q.addr, data: {7'h00, r_q.count}};
        if (done) st_d = NCD_S_DATA;
      end
      NCD_S_DATA: begin
        // program data comes from the stream, except single writes from the order itself;
        // one stream unit in flight at a time, since the writer cannot queue a second one
        if (r_q.op == ncd_pkg::NCD_PROGRAM || r_q.op == ncd_pkg::NCD_LOCK_WRITE) begin
          start = 1'b1;
          cyc   = '{addr: r_q.addr, data: r_q.data};
        end else if (wdata_valid && wrdy_q) begin
          start = 1'b1;
          cyc   = wdata;
          fly_d = 1'b1;
        end
        if (done) begin
          fly_d = 1'b0;
          if (r_q.op == ncd_pkg::NCD_LOCK_WRITE)
            lock_d = lock_q & (r_q.data | `NCD_LOCK_RSVD);
          if (left_q == 9'h000) begin
            if (r_q.op == ncd_pkg::NCD_BUFFER || r_q.op == ncd_pkg::NCD_ENH_BUFFER)
              st_d = NCD_S_TAIL;
            else begin
              rdy_d = 1'b1;
              st_d  = NCD_S_IDLE;
            end
          end else left_d = left_q - 9'h001;
        end
        wrdy_d = (r_q.op != ncd_pkg::NCD_PROGRAM) && (r_q.op != ncd_pkg::NCD_LOCK_WRITE) && !fly_d &&
                 !(done && left_q == 9'h000);
      end
      NCD_S_TAIL: begin
        start = 1'b1;
        // confirm at the same block address, or second bypass exit cycle
        if (r_q.op == ncd_pkg::NCD_BYP_EXIT)
          cyc = '{addr: r_q.addr, data: {8'h00, `NCD_CMD_BYP_EXIT2}};
        else
          cyc = '{addr: r_q.addr, data: {8'h00, `NCD_CMD_CONFIRM}};
        if (done) begin
          rdy_d = 1'b1;
          st_d  = NCD_S_IDLE;
        end
      end
      default: st_d = NCD_S_IDLE;
    endcase
  end

  // state registers; lock shadow starts at factory value (nonvolatile, all unprotected)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= NCD_S_IDLE;
      r_q    <= '0;
      left_q <= 9'h000;
      rdy_q  <= 1'b1;
      err_q  <= 1'b0;
      wrdy_q <= 1'b0;
      fly_q  <= 1'b0;
      lock_q <= `NCD_LOCK_DEFAULT;
    end else begin
      st_q   <= st_d;
      r_q    <= r_d;
      left_q <= left_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
      wrdy_q <= wrdy_d;
      fly_q  <= fly_d;
      lock_q <= lock_d;
    end
  end

  assign req_ready   = rdy_q;
  assign req_error   = err_q;
  assign wdata_ready = wrdy_q;
  assign lock_shadow = lock_q;

  // pin cycle timing lives in the writer; the writer ignores start while busy or showing done
  ncd_bus_writer u_writer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (start),
    .cyc   (cyc),
    .done  (done),
    .we_n  (flash_we_n),
    .addr  (flash_addr),
    .dq_o  (flash_dq_o),
    .dq_oe (flash_dq_oe)
  );
endmodule
`default_nettype wire

/* logic/ncd_pkg.sv */
// types for the flash command sequencer
package ncd_pkg;
  typedef enum logic [3:0] {
    NCD_RESET      = 4'h0,
    NCD_CFI        = 4'h1,
    NCD_AUTOSEL    = 4'h2,
    NCD_BYP_ENTER  = 4'h3,
    NCD_BYP_EXIT   = 4'h4,
    NCD_PROGRAM    = 4'h5,
    NCD_MULTI      = 4'h6,
    NCD_BUFFER     = 4'h7,
    NCD_ENH_BUFFER = 4'h8,
    NCD_LOCK_WRITE = 4'h9
  } ncd_op_type;
  // one bus write cycle to the device
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
  } ncd_cycle_type;
  // one user order
  typedef struct packed {
    ncd_op_type  op;
    logic        bypass;
    logic [23:0] addr;
    logic [15:0] data;
    logic [8:0]  count;
    logic [7:0]  multi_code;
  } ncd_req_type;
endpackage

/* tb/ncd_flash_model.sv */
// behavioural flash device: logs each write cycle and holds the lock register
`timescale 1ns/1ps
`default_nettype none
`include "ncd_cfg.svh"
module ncd_flash_model #(
  parameter logic [23:0] LOCK_ADDR = 24'h000000  // lock program target, arbitrary choice
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // flash pins
  input  wire logic        flash_we_n,
  input  wire logic [23:0] flash_addr,
  input  wire logic [15:0] flash_dq_o,
  // lock register contents
  output logic      [15:0] lock_q
);
  ncd_pkg::ncd_cycle_type log_q [256];
  int                     n_q;
  logic                   we_q;
  logic                   arm_q;
  logic            [15:0] nxt;
  // programming only clears bits; reserved bits never leave one
  assign nxt = lock_q & (flash_dq_o | `NCD_LOCK_RSVD);
  // a cycle is taken as we_n rises, while address and data are still held
  always_ff @(posedge clk) begin
    we_q <= flash_we_n;
    if (!rst_n) begin
      n_q    <= 0;
      arm_q  <= 1'b0;
      lock_q <= `NCD_LOCK_DEFAULT;
    end else if (flash_we_n && !we_q) begin
      log_q[n_q[7:0]] <= '{flash_addr, flash_dq_o};
      n_q             <= n_q + 1;
      arm_q           <= flash_dq_o[7:0] == `NCD_CMD_PROGRAM;
      // both mode bits low is refused, the old value stays
      if (arm_q && flash_addr == LOCK_ADDR && (nxt[2] || nxt[1])) lock_q <= nxt;
    end
  end
endmodule
`default_nettype wire

/* tb/ncd_host_monitor.sv */
// checker on the host sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "ncd_cfg.svh"
module ncd_host_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // user side
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        req_error,
  input wire logic        wdata_ready,
  input wire logic [15:0] lock_shadow,
  // flash pins
  input wire logic        flash_we_n,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_we_two_low: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
    else $error("write strobe width wrong");
  chk_drive_low: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data not driven in write");
  chk_pins_hold: assert property (!flash_we_n |=> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in write");
  chk_idle_quiet: assert property (req_ready |-> flash_we_n)
    else $error("write cycle while idle");
  chk_take_busy: assert property (req_valid && req_ready |=> !req_ready || req_error)
    else $error("order taken but still idle");
  chk_refuse_quiet: assert property (req_error |-> req_ready && flash_we_n)
    else $error("refused order touched the bus");
  chk_lock_rsvd: assert property ((lock_shadow & `NCD_LOCK_RSVD) == `NCD_LOCK_RSVD)
    else $error("reserved lock bits not one");
  chk_lock_once: assert property ((lock_shadow & ~$past(lock_shadow)) == 16'h0000)
    else $error("programmed lock bit returned");
  chk_mode_excl: assert property (lock_shadow[2] || lock_shadow[1])
    else $error("both mode lock bits low");
  chk_stream_busy: assert property (wdata_ready |-> !req_ready)
    else $error("stream taken while idle");
  cover property ($fell(flash_we_n));
  cover property (req_error);
  cover property (!lock_shadow[0]);
endmodule
bind ncd_host ncd_host_monitor u_ncd_host_monitor (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_ready(req_ready), .req_error(req_error), .wdata_ready(wdata_ready), .lock_shadow(lock_shadow),
  .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

/* tb/nor_command_decoder_lock_reg_tb.sv */
// self-checking bench for the host command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ncd_cfg.svh"
`define CHK(w, e, s) begin checked++; if ((e) !== (s)) begin error_cnt++; $display("mismatch %s exp %h got %h", w, e, s); end end
module nor_command_decoder_lock_reg_tb;
  // one case: op, {bypass, word mode, refused}, address, count, multi code
  typedef struct packed {
    logic [3:0]  op;
    logic [2:0]  f;
    logic [23:0] a;
    logic [8:0]  c;
    logic [7:0]  m;
  } ncd_row_type;
  localparam ncd_row_type ROWS [17] = '{
    '{4'h0, 3'h0, 24'h0, 9'h0, 8'h0}, '{4'h0, 3'h2, 24'h0, 9'h0, 8'h0}, '{4'h1, 3'h0, 24'h0, 9'h0, 8'h0},
    '{4'h1, 3'h2, 24'h0, 9'h0, 8'h0}, '{4'h2, 3'h2, 24'h0, 9'h0, 8'h0}, '{4'h5, 3'h0, 24'h1230, 9'h0, 8'h0},
    '{4'h6, 3'h0, 24'h40, 9'h7, 8'h8B}, '{4'h6, 3'h2, 24'h80, 9'h3, 8'h56}, '{4'h6, 3'h0, 24'hC0, 9'h1, 8'h50},
    '{4'h7, 3'h0, 24'h2000, 9'h3, 8'h0}, '{4'h8, 3'h2, 24'h3000, 9'h2, 8'h0}, '{4'h3, 3'h2, 24'h0, 9'h0, 8'h0},
    '{4'h5, 3'h6, 24'h1240, 9'h0, 8'h0}, '{4'h7, 3'h6, 24'h4000, 9'h1, 8'h0}, '{4'h4, 3'h6, 24'h100, 9'h0, 8'h0},
    '{4'h8, 3'h1, 24'h3000, 9'h2, 8'h0}, '{4'h7, 3'h1, 24'h2000, 9'h100, 8'h0}};
  logic                   clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, word_mode = 1'b0, wdata_valid = 1'b0;
  ncd_pkg::ncd_req_type   req = '0;
  ncd_pkg::ncd_cycle_type wdata = '0, got;
  logic                   req_ready, req_error, wdata_ready, flash_we_n, flash_dq_oe;
  logic [15:0]            lock_shadow, flash_dq_o, lock_q;
  logic [23:0]            flash_addr;
  ncd_pkg::ncd_cycle_type exp_q [$];
  bit                     care_q [$];
  int                     error_cnt = 0, checked = 0, cyc = 0;
  ncd_host u_ncd_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .word_mode(word_mode),
    .req_ready(req_ready), .req_error(req_error), .wdata_valid(wdata_valid), .wdata(wdata),
    .wdata_ready(wdata_ready), .lock_shadow(lock_shadow), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));
  ncd_flash_model u_ncd_flash_model (.clk(clk), .rst_n(rst_n), .flash_we_n(flash_we_n),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .lock_q(lock_q));
  always #2 clk = ~clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic push(logic [23:0] a, logic [7:0] d, bit c);
    exp_q.push_back('{a, {8'h00, d}});
    care_q.push_back(c);
  endtask
  // expected write cycles of one order; care bit off where any address does
  task automatic build(ncd_pkg::ncd_req_type r, logic wm);
    logic [23:0] u1;
    u1 = {12'h000, wm ? `NCD_UNLOCK1_X16 : `NCD_UNLOCK1_X8};
    if (!r.bypass && 4'(r.op) inside {4'h2, 4'h3, 4'h5, 4'h7, 4'h8}) begin
      push(u1, `NCD_KEY1, 1'b1);
      push({12'h000, wm ? `NCD_UNLOCK2_X16 : `NCD_UNLOCK2_X8}, `NCD_KEY2, 1'b1);
    end
    case (4'(r.op))
      4'h1: push({12'h000, wm ? `NCD_CFI_ADDR_X16 : `NCD_CFI_ADDR_X8}, `NCD_CMD_CFI, 1'b1);
      4'h2: push(u1, `NCD_CMD_AUTOSEL, 1'b1);
      4'h3: push(u1, `NCD_CMD_BYPASS, 1'b1);
      4'h4: begin
        push(u1, `NCD_CMD_AUTOSEL, 1'b0);
        push(r.addr, `NCD_CMD_BYP_EXIT2, 1'b1);
      end
      4'h5: push(u1, `NCD_CMD_PROGRAM, !r.bypass);
      4'h6: push(u1, r.multi_code, 1'b1);
      4'h7: begin
        push(r.addr, `NCD_CMD_BUFFER, 1'b1);
        push(r.addr, r.count[7:0], 1'b1);
      end
      4'h8: push(r.addr, `NCD_CMD_ENH_BUF, 1'b1);
      default: ;
    endcase
    if (4'(r.op) == 4'h5) exp_q.push_back('{r.addr, r.data});
    if (4'(r.op) == 4'h5) care_q.push_back(1'b1);
    for (int i = 0; 4'(r.op) inside {4'h6, 4'h7, 4'h8} && i <= r.count; i++) begin
      exp_q.push_back('{r.addr + 24'(i), 16'hC000 + 16'(i)});
      care_q.push_back(1'b1);
    end
    if (4'(r.op) inside {4'h7, 4'h8}) push(r.addr, `NCD_CMD_CONFIRM, 1'b1);
  endtask
  // stream feeder: each unit held until wdata_ready is seen at an edge
  task automatic feed(ncd_pkg::ncd_req_type r);
    for (int i = 0; i <= r.count; i++) begin
      wdata = '{r.addr + 24'(i), 16'hC000 + 16'(i)};
      wdata_valid = 1'b1;
      do @(posedge clk); while (wdata_ready !== 1'b1);
      #1;
    end
    wdata_valid = 1'b0;
  endtask
  task automatic order(ncd_pkg::ncd_req_type r, logic wm, logic rf);
    int n0;
    int t;
    n0 = u_ncd_flash_model.n_q;
    exp_q.delete();
    care_q.delete();
    if (!rf) build(r, wm);
    req = r;
    word_mode = wm;
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
    // the refusal pulse stands only in the cycle right after the take
    `CHK("refusal", rf, req_error)
    fork
      if (!rf && 4'(r.op) inside {4'h6, 4'h7, 4'h8}) feed(r);
    join_none
    for (t = 0; t < 3000 && req_ready !== 1'b1; t++) @(posedge clk);
    #1 t = u_ncd_flash_model.n_q - 1;
    `CHK("order end", 1'b1, req_ready)
    got = u_ncd_flash_model.log_q[t % 256];
    if (4'(r.op) == 4'h0) `CHK("reset code", 16'h00F0, got.data)
    else if (4'(r.op) != 4'h9 || rf) begin
      `CHK("cycle count", exp_q.size(), u_ncd_flash_model.n_q - n0)
      foreach (exp_q[k]) begin
        got = u_ncd_flash_model.log_q[(n0 + k) % 256];
        `CHK("cycle data", exp_q[k].data, got.data)
        if (care_q[k]) `CHK("cycle addr", exp_q[k].addr, got.addr)
      end
    end
    $display("test op %0d word %0d done", r.op, wm);
  endtask
  task automatic lock_step(logic [15:0] d, logic rf, logic [15:0] e);
    order('{ncd_pkg::NCD_LOCK_WRITE, 1'b0, 24'h0, d, 9'h0, 8'h0}, 1'b0, rf);
    `CHK("lock shadow", e, lock_shadow)
    `CHK("lock register", e, lock_q)
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("reset lock", `NCD_LOCK_DEFAULT, lock_shadow)
    @(posedge clk);
    #1;
    for (int i = 0; i < 17; i++)
      order('{ncd_pkg::ncd_op_type'(ROWS[i].op), ROWS[i].f[2], ROWS[i].a, 16'h00C3, ROWS[i].c, ROWS[i].m},
        ROWS[i].f[1], ROWS[i].f[0]);
    lock_step(16'hFFFE, 1'b0, 16'hFFFE);
    lock_step(16'hFFFB, 1'b0, 16'hFFFA);
    lock_step(16'hFFFD, 1'b1, 16'hFFFA);
    lock_step(16'hFFFF, 1'b0, 16'hFFFA);
    // second reset in mid-run: pins quiet, shadow back to factory state
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK("reset ready", 1'b1, req_ready)
    `CHK("reset strobe", 1'b1, flash_we_n)
    `CHK("reset shadow", `NCD_LOCK_DEFAULT, lock_shadow)
    // release mid-run and offer a fresh order at once
    rst_n = 1'b1;
    order('{ncd_pkg::NCD_CFI, 1'b0, 24'h0, 16'h00C3, 9'h0, 8'h0}, 1'b0, 1'b0);
    $display("test reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
